//--- tmr_pkg.sv
// constants, field layouts and carrier types for the 8-bit waveform timer
// Notes on behaviour
// [RULE1] counter is synchronous to the system clock; tick only qualifies steps
// [RULE2] tick comes each clock when undivided, else from prescaler or from a pin edge; counting and flags advance only then
// [RULE3] nonzero out_mode_a puts compare_out_a on pad; drive only with direction set
// [RULE4] same pad override for channel B with out_mode_b and its direction bit
// [RULE5] plain modes, channel A: 0 off, 1 toggle, 2 clear, 3 set on match
// [RULE6] fast PWM A: 1 toggles only with wave_mode_high; 2/3 match and bottom levels
// [RULE7] phase PWM A: 1 toggles only with wave_mode_high; 2/3 up and down levels
// [RULE8] plain modes, channel B: 0 off, 1 toggle, 2 clear, 3 set on match
// [RULE9] fast PWM B: value 1 reserved; 2/3 match and bottom levels
// [RULE10] phase PWM B: value 1 reserved; 2/3 up and down match levels
// [RULE11] fast PWM: compare equal top with mode high bit ignores match; bottom action only
// [RULE12] phase PWM: compare equal top with mode high bit ignores match; action at top
// [RULE13] control bits 3 and 2 read as zero
// [RULE14] wave mode selects count sequence and top; 4 and 6 reserved
// [RULE15] compare update immediate in plain modes, at top in phase, at bottom in fast
// [RULE16] overflow flag at max in 0,2,3, at bottom in 1,5, at top in 7
// [RULE17] compare-A-as-top plain and fast modes: match A sets flag and clears count
// [RULE18] flag B set on every match; flag A likewise
// [RULE19] clock select: stop, undivided, /8 /64 /256 /1024, pin falling or rising
// [RULE20] fast PWM counts up to top then returns to zero next tick
// [RULE21] normal mode rolls from maximum to zero on the next tick
package tmr_pkg;
   localparam logic [11:0] TMR_OFS_CTRL_A  = 12'h030;
   localparam logic [11:0] TMR_OFS_CTRL_B  = 12'h034;
   localparam logic [11:0] TMR_OFS_COUNT   = 12'h038;
   localparam logic [11:0] TMR_OFS_CMP_A   = 12'h03C;
   localparam logic [11:0] TMR_OFS_CMP_B   = 12'h040;
   localparam logic [11:0] TMR_OFS_FLAGS   = 12'h044;
   localparam logic [11:0] TMR_OFS_PIN_DIR = 12'h048;

   localparam int TMR_CB_FORCE_A = 7;
   localparam int TMR_CB_FORCE_B = 6;
   localparam int TMR_FLAG_B     = 2;
   localparam int TMR_FLAG_A     = 1;
   localparam int TMR_FLAG_OV    = 0;
   localparam int TMR_DIR_A      = 0;
   localparam int TMR_DIR_B      = 1;

   localparam logic [7:0] TMR_MAX      = 8'hFF;
   localparam logic [7:0] TMR_BOTTOM   = 8'h00;
   localparam logic [7:0] TMR_ONE      = 8'h01;
   localparam logic [7:0] TMR_CTRL_RST = 8'h00;

   localparam logic [2:0] TMR_CS_STOP     = 3'h0;
   localparam logic [2:0] TMR_CS_DIV1     = 3'h1;
   localparam logic [2:0] TMR_CS_DIV8     = 3'h2;
   localparam logic [2:0] TMR_CS_DIV64    = 3'h3;
   localparam logic [2:0] TMR_CS_DIV256   = 3'h4;
   localparam logic [2:0] TMR_CS_DIV1024  = 3'h5;
   localparam logic [2:0] TMR_CS_EXT_FALL = 3'h6;
   localparam logic [2:0] TMR_CS_EXT_RISE = 3'h7;

   localparam logic [9:0] TMR_PRE_M8    = 10'h007;
   localparam logic [9:0] TMR_PRE_M64   = 10'h03F;
   localparam logic [9:0] TMR_PRE_M256  = 10'h0FF;
   localparam logic [9:0] TMR_PRE_M1024 = 10'h3FF;

   localparam logic [2:0] TMR_WM_NORMAL   = 3'h0;
   localparam logic [2:0] TMR_WM_PHASE_FF = 3'h1;
   localparam logic [2:0] TMR_WM_CLR_TOP  = 3'h2;
   localparam logic [2:0] TMR_WM_FAST_FF  = 3'h3;
   localparam logic [2:0] TMR_WM_PHASE_CA = 3'h5;
   localparam logic [2:0] TMR_WM_FAST_CA  = 3'h7;

   localparam logic [1:0] TMR_OM_OFF    = 2'h0;
   localparam logic [1:0] TMR_OM_TOGGLE = 2'h1;
   localparam logic [1:0] TMR_OM_CLEAR  = 2'h2;
   localparam logic [1:0] TMR_OM_SET    = 2'h3;

   typedef enum {TMR_CLS_PLAIN, TMR_CLS_FAST, TMR_CLS_PHASE} tmr_class_e;

   typedef struct packed {
      logic [1:0] out_mode_a;
      logic [1:0] out_mode_b;
      logic [1:0] rsv;
      logic [1:0] wave_mode_low;
   } tmr_ctrl_a_s;

   typedef struct packed {
      logic       force_a;
      logic       force_b;
      logic [1:0] rsv;
      logic       wave_mode_high;
      logic [2:0] clock_select_field;
   } tmr_ctrl_b_s;
endpackage

//--- tmr_wave_ctrl.sv
// 8-bit timer with waveform mode control, two compare channels and APB registers
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module tmr_wave_ctrl
   import tmr_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        RST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        EXT_TICK_PIN,
   input  wire logic        PORT_A_OUT,
   input  wire logic        PORT_B_OUT,
   output logic             PAD_A_O,
   output logic             PAD_A_OE,
   output logic             PAD_B_O,
   output logic             PAD_B_OE
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   tmr_ctrl_a_s ctrl_a_r;
   tmr_ctrl_b_s ctrl_b_r;
   logic [7:0]  cnt_r;
   logic        dir_down_r;
   logic [7:0]  buf_a_r;
   logic [7:0]  buf_b_r;
   logic [7:0]  ocr_a_r;
   logic [7:0]  ocr_b_r;
   logic [2:0]  flags_r;
   logic [1:0]  pin_dir_r;
   logic        block_r;
   logic        oc_a_r;
   logic        oc_b_r;
   logic [9:0]  pre_r;
   logic [2:0]  ext_s_r;
   logic        ext_lvl_r;
   logic        ext_prev_r;
   logic [31:0] prdata_r;
   logic [31:0] rd_data;
   logic        rd_err;
   logic        wr_acc;
   logic        cnt_wr;
   logic        cmp_a_wr;
   logic        cmp_b_wr;
   logic        tick_en;
   logic [2:0]  wmode;
   tmr_class_e  cls;
   logic [7:0]  top_w;
   logic        step;
   logic        wrap_evt;
   logic        match_a;
   logic        match_b;
   logic        force_a;
   logic        force_b;
   logic        ov_evt;
   logic        upd_evt;

   function automatic tmr_class_e wave_class(input logic [2:0] m);
      tmr_class_e c;
      c = TMR_CLS_PLAIN;
      if (m == TMR_WM_FAST_FF || m == TMR_WM_FAST_CA) begin
         c = TMR_CLS_FAST;
      end else if (m == TMR_WM_PHASE_FF || m == TMR_WM_PHASE_CA) begin
         c = TMR_CLS_PHASE;
      end
      return c;
   endfunction

   // next level of one compare output; edge_evt is bottom wrap (fast) or top (phase)
   function automatic logic oc_next(input logic oc, input logic [1:0] com, input logic tgl_ok,
                                    input tmr_class_e c, input logic hit, input logic edge_evt,
                                    input logic down, input logic cmp_is_top);
      logic res;
      res = oc;
      case (c)
         TMR_CLS_PLAIN: begin
            if (hit) begin
               case (com)
                  TMR_OM_TOGGLE: res = ~oc;
                  TMR_OM_CLEAR:  res = 1'b0;
                  TMR_OM_SET:    res = 1'b1;
                  default:       res = oc;
               endcase
            end
         end
         TMR_CLS_FAST: begin
            if (com[1]) begin
               if (edge_evt) begin
                  res = (com == TMR_OM_CLEAR);
               end else if (hit && !cmp_is_top) begin
                  res = (com == TMR_OM_SET);
               end
            end else if (com == TMR_OM_TOGGLE && tgl_ok && hit) begin
               res = ~oc;
            end
         end
         default: begin
            if (com[1]) begin
               if (cmp_is_top) begin
                  if (edge_evt) begin
                     res = (com == TMR_OM_SET);
                  end
               end else if (hit) begin
                  res = (com == TMR_OM_SET) ^ down;
               end
            end else if (com == TMR_OM_TOGGLE && tgl_ok && hit) begin
               res = ~oc;
            end
         end
      endcase
      return res;
   endfunction

   // zero-wait slave: every access completes in its first access cycle
   assign PREADY   = 1'b1;
   assign wr_acc   = PSEL && PENABLE && PWRITE;
   assign cnt_wr   = wr_acc && PADDR == TMR_OFS_COUNT;
   assign cmp_a_wr = wr_acc && PADDR == TMR_OFS_CMP_A;
   assign cmp_b_wr = wr_acc && PADDR == TMR_OFS_CMP_B;

   assign wmode = {ctrl_b_r.wave_mode_high, ctrl_a_r.wave_mode_low};
   assign cls   = wave_class(wmode);
   // reserved modes 4 and 6 fall back to a free 8-bit count
   assign top_w = (wmode == TMR_WM_CLR_TOP || wmode == TMR_WM_PHASE_CA || wmode == TMR_WM_FAST_CA) ?
                  ocr_a_r : TMR_MAX; // RULE14

   // strobes only act in plain modes and never raise a flag or clear the count
   assign force_a = wr_acc && PADDR == TMR_OFS_CTRL_B && PWDATA[TMR_CB_FORCE_A] && cls == TMR_CLS_PLAIN;
   assign force_b = wr_acc && PADDR == TMR_OFS_CTRL_B && PWDATA[TMR_CB_FORCE_B] && cls == TMR_CLS_PLAIN;

   // registers
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         ctrl_a_r  <= TMR_CTRL_RST;
         ctrl_b_r  <= TMR_CTRL_RST;
         pin_dir_r <= 2'h0;
         buf_a_r   <= TMR_BOTTOM;
         buf_b_r   <= TMR_BOTTOM;
      end else if (wr_acc) begin
         if (PADDR == TMR_OFS_CTRL_A) begin
            ctrl_a_r     <= PWDATA[7:0];
            ctrl_a_r.rsv <= 2'h0; // RULE13
         end else if (PADDR == TMR_OFS_CTRL_B) begin
            ctrl_b_r         <= PWDATA[7:0];
            ctrl_b_r.force_a <= 1'b0;
            ctrl_b_r.force_b <= 1'b0;
            ctrl_b_r.rsv     <= 2'h0;
         end else if (PADDR == TMR_OFS_CMP_A) begin
            buf_a_r <= PWDATA[7:0];
         end else if (PADDR == TMR_OFS_CMP_B) begin
            buf_b_r <= PWDATA[7:0];
         end else if (PADDR == TMR_OFS_PIN_DIR) begin
            pin_dir_r <= PWDATA[1:0];
         end
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      if (PADDR == TMR_OFS_CTRL_A) begin
         rd_data[7:0] = ctrl_a_r;
      end else if (PADDR == TMR_OFS_CTRL_B) begin
         rd_data[7:0] = ctrl_b_r;
      end else if (PADDR == TMR_OFS_COUNT) begin
         rd_data[7:0] = cnt_r;
      end else if (PADDR == TMR_OFS_CMP_A) begin
         rd_data[7:0] = buf_a_r;
      end else if (PADDR == TMR_OFS_CMP_B) begin
         rd_data[7:0] = buf_b_r;
      end else if (PADDR == TMR_OFS_FLAGS) begin
         rd_data[2:0] = flags_r;
      end else if (PADDR == TMR_OFS_PIN_DIR) begin
         rd_data[1:0] = pin_dir_r;
      end else begin
         rd_err = 1'b1;
      end
   end

   // read data caught in the setup cycle so it leaves a flop in the access cycle
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         prdata_r <= 32'h0000_0000;
      end else if (PSEL && !PENABLE && !PWRITE) begin
         prdata_r <= rd_data;
      end
   end
   assign PRDATA  = prdata_r;
   assign PSLVERR = PSEL && PENABLE && rd_err;

   // prescaler and pin edge detection; three flops, level taken once two agree
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         pre_r      <= 10'h000;
         ext_s_r    <= 3'h0;
         ext_lvl_r  <= 1'b0;
         ext_prev_r <= 1'b0;
      end else begin
         pre_r      <= pre_r + 10'h001;
         ext_s_r    <= {ext_s_r[1:0], EXT_TICK_PIN};
         ext_lvl_r  <= (ext_s_r[1] == ext_s_r[2]) ? ext_s_r[2] : ext_lvl_r;
         ext_prev_r <= ext_lvl_r;
      end
   end

   always_comb begin
      case (ctrl_b_r.clock_select_field) // RULE19
         TMR_CS_DIV1:     tick_en = 1'b1; // RULE2
         TMR_CS_DIV8:     tick_en = (pre_r[2:0] == TMR_PRE_M8[2:0]);
         TMR_CS_DIV64:    tick_en = (pre_r[5:0] == TMR_PRE_M64[5:0]);
         TMR_CS_DIV256:   tick_en = (pre_r[7:0] == TMR_PRE_M256[7:0]);
         TMR_CS_DIV1024:  tick_en = (pre_r == TMR_PRE_M1024);
         TMR_CS_EXT_FALL: tick_en = ext_prev_r && !ext_lvl_r;
         TMR_CS_EXT_RISE: tick_en = !ext_prev_r && ext_lvl_r;
         default:         tick_en = 1'b0;
      endcase
   end

   // a software count write wins over a tick and blocks a match on the next tick
   assign step     = tick_en && !cnt_wr; // RULE1
   assign wrap_evt = step && cnt_r == top_w && !(cls == TMR_CLS_PHASE && dir_down_r);
   assign match_a  = step && !block_r && cnt_r == ocr_a_r;
   assign match_b  = step && !block_r && cnt_r == ocr_b_r;
   assign ov_evt   = (cls == TMR_CLS_PHASE) ? (step && dir_down_r && cnt_r == TMR_BOTTOM) :
                     (wmode == TMR_WM_FAST_CA) ? wrap_evt : (step && cnt_r == TMR_MAX); // RULE16
   assign upd_evt  = (cls != TMR_CLS_PLAIN) && wrap_evt; // RULE15

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         cnt_r      <= TMR_BOTTOM;
         dir_down_r <= 1'b0;
      end else if (cnt_wr) begin
         cnt_r <= PWDATA[7:0];
      end else if (tick_en) begin
         if (cls == TMR_CLS_PHASE) begin
            if (!dir_down_r && cnt_r == top_w) begin
               dir_down_r <= 1'b1;
               cnt_r      <= (cnt_r == TMR_BOTTOM) ? TMR_BOTTOM : cnt_r - TMR_ONE;
            end else if (dir_down_r && cnt_r == TMR_BOTTOM) begin
               dir_down_r <= 1'b0;
               cnt_r      <= (top_w == TMR_BOTTOM) ? TMR_BOTTOM : TMR_ONE;
            end else begin
               cnt_r <= dir_down_r ? cnt_r - TMR_ONE : cnt_r + TMR_ONE;
            end
         end else begin
            dir_down_r <= 1'b0;
            cnt_r      <= (cnt_r == top_w) ? TMR_BOTTOM : cnt_r + TMR_ONE; // RULE17 RULE20 RULE21
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         block_r <= 1'b0;
      end else if (cnt_wr) begin
         block_r <= 1'b1;
      end else if (tick_en) begin
         block_r <= 1'b0;
      end
   end

   // active compare values; plain modes see a write in the same edge
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         ocr_a_r <= TMR_BOTTOM;
         ocr_b_r <= TMR_BOTTOM;
      end else if (cls == TMR_CLS_PLAIN) begin
         ocr_a_r <= cmp_a_wr ? PWDATA[7:0] : buf_a_r; // RULE15
         ocr_b_r <= cmp_b_wr ? PWDATA[7:0] : buf_b_r;
      end else if (upd_evt) begin
         ocr_a_r <= buf_a_r;
         ocr_b_r <= buf_b_r;
      end
   end

   // set wins over a write-one clear in the same cycle
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         flags_r <= 3'h0;
      end else begin
         flags_r[TMR_FLAG_OV] <= ov_evt ||
            (flags_r[TMR_FLAG_OV] && !(wr_acc && PADDR == TMR_OFS_FLAGS && PWDATA[TMR_FLAG_OV]));
         flags_r[TMR_FLAG_A]  <= match_a || // RULE17 RULE18
            (flags_r[TMR_FLAG_A] && !(wr_acc && PADDR == TMR_OFS_FLAGS && PWDATA[TMR_FLAG_A]));
         flags_r[TMR_FLAG_B]  <= match_b || // RULE18
            (flags_r[TMR_FLAG_B] && !(wr_acc && PADDR == TMR_OFS_FLAGS && PWDATA[TMR_FLAG_B]));
      end
   end

   // channel B never toggles in PWM; channel A only with wave_mode_high
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         oc_a_r <= 1'b0;
         oc_b_r <= 1'b0;
      end else begin
         oc_a_r <= oc_next(oc_a_r, ctrl_a_r.out_mode_a, ctrl_b_r.wave_mode_high, cls, match_a || force_a,
                           wrap_evt, dir_down_r, ocr_a_r == top_w); // RULE5 RULE6 RULE7 RULE11 RULE12
         oc_b_r <= oc_next(oc_b_r, ctrl_a_r.out_mode_b, 1'b0, cls, match_b || force_b,
                           wrap_evt, dir_down_r, ocr_b_r == top_w); // RULE8 RULE9 RULE10 RULE11 RULE12
      end
   end

   assign PAD_A_O  = (ctrl_a_r.out_mode_a != TMR_OM_OFF) ? oc_a_r : PORT_A_OUT; // RULE3
   assign PAD_A_OE = pin_dir_r[TMR_DIR_A];
   assign PAD_B_O  = (ctrl_a_r.out_mode_b != TMR_OM_OFF) ? oc_b_r : PORT_B_OUT; // RULE4
   assign PAD_B_OE = pin_dir_r[TMR_DIR_B];

   property p_count_hold;
      !tick_en && !cnt_wr |=> $stable(cnt_r);
   endproperty
   a_count_hold: assert property (p_count_hold) else $error("count moved without a tick"); // RULE1

   property p_stop;
      ctrl_b_r.clock_select_field == TMR_CS_STOP |-> !tick_en;
   endproperty
   a_stop: assert property (p_stop) else $error("tick while stopped"); // RULE2

   property p_pad_a;
      ctrl_a_r.out_mode_a != TMR_OM_OFF |-> PAD_A_O == oc_a_r && PAD_A_OE == pin_dir_r[TMR_DIR_A];
   endproperty
   a_pad_a: assert property (p_pad_a) else $error("pad A not overridden"); // RULE3

   property p_pad_b;
      ctrl_a_r.out_mode_b == TMR_OM_OFF |-> PAD_B_O == PORT_B_OUT;
   endproperty
   a_pad_b: assert property (p_pad_b) else $error("pad B overridden while off"); // RULE4

   property p_rsv_zero;
      PSEL && PENABLE && !PWRITE && PADDR == TMR_OFS_CTRL_A |-> PRDATA[3:2] == 2'h0;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved control bits read nonzero"); // RULE13

   property p_roll;
      wmode == TMR_WM_NORMAL && step && cnt_r == TMR_MAX |=> cnt_r == TMR_BOTTOM && flags_r[TMR_FLAG_OV];
   endproperty
   a_roll: assert property (p_roll) else $error("normal mode roll or overflow wrong"); // RULE21

   // a match right after a count write is blocked: count still clears, flag stays
   property p_match_clear;
      wmode == TMR_WM_CLR_TOP && step && cnt_r == ocr_a_r |=>
         cnt_r == TMR_BOTTOM && (flags_r[TMR_FLAG_A] || $past(block_r));
   endproperty
   a_match_clear: assert property (p_match_clear) else $error("match A did not clear count"); // RULE17

   property p_immediate;
      cls == TMR_CLS_PLAIN && cmp_a_wr |=> ocr_a_r == $past(PWDATA[7:0]);
   endproperty
   a_immediate: assert property (p_immediate) else $error("plain mode compare not immediate"); // RULE15

   property p_fast_bottom;
      wmode == TMR_WM_FAST_FF && ctrl_a_r.out_mode_a == TMR_OM_CLEAR && wrap_evt |=> oc_a_r;
   endproperty
   a_fast_bottom: assert property (p_fast_bottom) else $error("fast PWM bottom set missing"); // RULE6

   property p_flag_b;
      match_b |=> flags_r[TMR_FLAG_B] ##1 flags_r[TMR_FLAG_B] || $past(wr_acc);
   endproperty
   a_flag_b: assert property (p_flag_b) else $error("flag B not set on match"); // RULE18

   property p_div1;
      ctrl_b_r.clock_select_field == TMR_CS_DIV1 |-> tick_en;
   endproperty
   a_div1: assert property (p_div1) else $error("undivided tick missing"); // RULE19

   property p_fast_wrap;
      cls == TMR_CLS_FAST && step && cnt_r == top_w |=> cnt_r == TMR_BOTTOM;
   endproperty
   a_fast_wrap: assert property (p_fast_wrap) else $error("fast PWM count did not return to zero"); // RULE20
endmodule
`default_nettype wire

//--- test_tmr_wave_ctrl.sv
// self-checking bench for the waveform timer control block
`timescale 1ns/10ps
`default_nettype none
module test_tmr_wave_ctrl;
   import tmr_pkg::*;

   typedef struct packed {
      logic [7:0]  ctl_a;
      logic [7:0]  ctl_b;
      logic [7:0]  cmp_a;
      logic [7:0]  cmp_b;
      logic        lvl_a;
      logic        lvl_b;
      logic [15:0] run_a;
      logic [15:0] run_b;
   } tmr_row_s;

   // run lengths in clocks at the chosen level; zero skips the channel
   localparam tmr_row_s ROWS [12] = '{
      '{8'h52, 8'h01, 8'h03, 8'h01, 1'b1, 1'b1, 16'h0004, 16'h0004},
      '{8'hB3, 8'h01, 8'h40, 8'h10, 1'b1, 1'b0, 16'h0041, 16'h0011},
      '{8'h63, 8'h09, 8'h20, 8'h08, 1'b1, 1'b1, 16'h0021, 16'h0009},
      '{8'hE1, 8'h01, 8'h80, 8'h80, 1'b1, 1'b0, 16'h00FE, 16'h00FE},
      '{8'h61, 8'h09, 8'h40, 8'h10, 1'b1, 1'b0, 16'h0080, 16'h0060},
      '{8'h40, 8'h09, 8'h10, 8'h00, 1'b1, 1'b0, 16'h0100, 16'h0000},
      '{8'h42, 8'h02, 8'h03, 8'h00, 1'b1, 1'b0, 16'h0020, 16'h0000},
      '{8'h42, 8'h03, 8'h03, 8'h00, 1'b1, 1'b0, 16'h0100, 16'h0000},
      '{8'h42, 8'h04, 8'h00, 8'h00, 1'b1, 1'b0, 16'h0100, 16'h0000},
      '{8'h42, 8'h07, 8'h00, 8'h00, 1'b1, 1'b0, 16'h0014, 16'h0000},
      '{8'h42, 8'h06, 8'h00, 8'h00, 1'b1, 1'b0, 16'h0014, 16'h0000},
      '{8'h42, 8'h05, 8'h00, 8'h00, 1'b1, 1'b0, 16'h0400, 16'h0000}
   };

   logic        CLK_SYS;
   logic        RST_N;
   logic        PSEL;
   logic        PENABLE;
   logic        PWRITE;
   logic [11:0] PADDR;
   logic [31:0] PWDATA;
   logic [31:0] PRDATA;
   logic        PREADY;
   logic        PSLVERR;
   logic        EXT_TICK_PIN;
   logic        PORT_A_OUT;
   logic        PORT_B_OUT;
   logic        PAD_A_O;
   logic        PAD_A_OE;
   logic        PAD_B_O;
   logic        PAD_B_OE;
   logic [31:0] rd;
   logic        serr;
   int          err_count;
   int          num_checks;
   int          n;

   tmr_wave_ctrl u_dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .EXT_TICK_PIN(EXT_TICK_PIN), .PORT_A_OUT(PORT_A_OUT),
      .PORT_B_OUT(PORT_B_OUT), .PAD_A_O(PAD_A_O), .PAD_A_OE(PAD_A_OE), .PAD_B_O(PAD_B_O),
      .PAD_B_OE(PAD_B_OE));

   initial begin
      CLK_SYS = 1'b0;
      forever #10 CLK_SYS = ~CLK_SYS;
   end

   // pin toggles every 10 clocks, so each edge kind comes every 20
   initial begin
      EXT_TICK_PIN = 1'b0;
      forever begin
         repeat (10) @(posedge CLK_SYS);
         EXT_TICK_PIN <= ~EXT_TICK_PIN;
      end
   end

   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int k;
      @(posedge CLK_SYS);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK_SYS);
      PENABLE <= 1'b1;
      k = 0;
      do begin
         @(posedge CLK_SYS);
         k++;
      end while (PREADY !== 1'b1 && k < 50);
      q = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (k >= 50) begin
         err_count++;
         $display("BAD bus answer never came");
         results();
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d}, rd, serr);
   endtask

   task automatic rdc(input string nm, input logic [11:0] a, input logic [7:0] x);
      apb(1'b0, a, 32'h0, rd, serr);
      chk(nm, rd, {24'h0, x});
   endtask

   function automatic logic pad(input logic b);
      return b ? PAD_B_O : PAD_A_O;
   endfunction

   // stop first so the new mode starts from a known count
   task automatic setup(input tmr_row_s r);
      wr(TMR_OFS_CTRL_B, 8'h00);
      wr(TMR_OFS_COUNT, 8'h00);
      wr(TMR_OFS_CTRL_A, r.ctl_a);
      wr(TMR_OFS_CMP_A, r.cmp_a);
      wr(TMR_OFS_CMP_B, r.cmp_b);
      wr(TMR_OFS_CTRL_B, r.ctl_b);
      repeat (1100) @(posedge CLK_SYS);
   endtask

   // length of one whole run of the pad at lvl
   task automatic run(input logic b, input logic lvl, output int len);
      int k;
      len = 0;
      k = 0;
      while (pad(b) === lvl && k < 5000) begin
         @(posedge CLK_SYS);
         k++;
      end
      while (pad(b) !== lvl && k < 5000) begin
         @(posedge CLK_SYS);
         k++;
      end
      while (pad(b) === lvl && k < 5000) begin
         @(posedge CLK_SYS);
         k++;
         len++;
      end
      if (k >= 5000) begin
         err_count++;
         $display("BAD pad run never ended");
         results();
      end
   endtask

   task automatic watch(input logic b, output int chg);
      logic prv;
      chg = 0;
      prv = pad(b);
      repeat (600) begin
         @(posedge CLK_SYS);
         if (pad(b) !== prv) chg++;
         prv = pad(b);
      end
   endtask

   initial begin
      RST_N = 1'b0;
      PSEL = 1'b0;
      PENABLE = 1'b0;
      PWRITE = 1'b0;
      PADDR = 12'h000;
      PWDATA = 32'h0;
      PORT_A_OUT = 1'b1;
      PORT_B_OUT = 1'b0;
      err_count = 0;
      num_checks = 0;
      repeat (5) @(posedge CLK_SYS);
      RST_N <= 1'b1;
      rdc("ctrl_a_reset", TMR_OFS_CTRL_A, 8'h00);
      wr(TMR_OFS_CTRL_A, 8'hFF);
      rdc("ctrl_a_rsv", TMR_OFS_CTRL_A, 8'hF3);
      wr(TMR_OFS_CTRL_A, 8'h00);
      wr(TMR_OFS_COUNT, 8'h55);
      repeat (20) @(posedge CLK_SYS);
      rdc("count_stopped", TMR_OFS_COUNT, 8'h55);
      apb(1'b0, 12'h04C, 32'h0, rd, serr);
      chk("unmapped_err", {31'h0, serr}, 32'h1);
      chk("unmapped_data", rd, 32'h0);
      wr(TMR_OFS_PIN_DIR, 8'h01);
      @(posedge CLK_SYS);
      chk("pad_a_port", {31'h0, PAD_A_O}, 32'h1);
      chk("pad_a_oe", {31'h0, PAD_A_OE}, 32'h1);
      chk("pad_b_port", {31'h0, PAD_B_O}, 32'h0);
      chk("pad_b_oe", {31'h0, PAD_B_OE}, 32'h0);
      wr(TMR_OFS_PIN_DIR, 8'h03);
      $display("done: registers and pads");
      wr(TMR_OFS_COUNT, 8'hFE);
      wr(TMR_OFS_FLAGS, 8'h07);
      wr(TMR_OFS_CTRL_B, 8'h01);
      wr(TMR_OFS_CTRL_B, 8'h00);
      apb(1'b0, TMR_OFS_FLAGS, 32'h0, rd, serr);
      chk("overflow_max", {31'h0, rd[0]}, 32'h1);
      apb(1'b0, TMR_OFS_COUNT, 32'h0, rd, serr);
      chk("count_wrapped", {31'h0, rd[7:0] < 8'h10}, 32'h1);
      wr(TMR_OFS_FLAGS, 8'h07);
      repeat (20) @(posedge CLK_SYS);
      rdc("flags_idle", TMR_OFS_FLAGS, 8'h00);
      $display("done: normal rollover");
      foreach (ROWS[i]) begin
         setup(ROWS[i]);
         if (ROWS[i].run_a != 16'h0) begin
            run(1'b0, ROWS[i].lvl_a, n);
            chk("run_a", 32'(n), {16'h0, ROWS[i].run_a});
         end
         if (ROWS[i].run_b != 16'h0) begin
            run(1'b1, ROWS[i].lvl_b, n);
            chk("run_b", 32'(n), {16'h0, ROWS[i].run_b});
         end
         $display("done: row %0d", i);
      end
      // last row holds count at 0, so both matches fire every tick
      wr(TMR_OFS_FLAGS, 8'h07);
      repeat (2100) @(posedge CLK_SYS);
      rdc("flags_match", TMR_OFS_FLAGS, 8'h06);
      setup('{8'h23, 8'h01, 8'h10, 8'hFF, 1'b0, 1'b0, 16'h0, 16'h0});
      watch(1'b1, n);
      chk("fast_top_b", 32'(n), 32'h0);
      chk("fast_top_lvl", {31'h0, PAD_B_O}, 32'h1);
      setup('{8'h21, 8'h01, 8'h10, 8'hFF, 1'b0, 1'b0, 16'h0, 16'h0});
      watch(1'b1, n);
      chk("phase_top_b", 32'(n), 32'h0);
      chk("phase_top_lvl", {31'h0, PAD_B_O}, 32'h0);
      setup('{8'h53, 8'h01, 8'h10, 8'h10, 1'b0, 1'b0, 16'h0, 16'h0});
      watch(1'b0, n);
      chk("fast_a_one", 32'(n), 32'h0);
      watch(1'b1, n);
      chk("fast_b_one", 32'(n), 32'h0);
      $display("done: top and reserved cases");
      // forced matches in a stopped plain mode: set, then clear, no flag
      wr(TMR_OFS_CTRL_B, 8'h00);
      wr(TMR_OFS_CTRL_A, 8'hC0);
      wr(TMR_OFS_FLAGS, 8'h07);
      wr(TMR_OFS_CTRL_B, 8'h80);
      @(posedge CLK_SYS);
      chk("force_set", {31'h0, PAD_A_O}, 32'h1);
      wr(TMR_OFS_CTRL_A, 8'h80);
      wr(TMR_OFS_CTRL_B, 8'h80);
      @(posedge CLK_SYS);
      chk("force_clear", {31'h0, PAD_A_O}, 32'h0);
      rdc("force_no_flag", TMR_OFS_FLAGS, 8'h00);
      rdc("force_reads_zero", TMR_OFS_CTRL_B, 8'h00);
      $display("done: forced matches");
      RST_N <= 1'b0;
      repeat (5) @(posedge CLK_SYS);
      RST_N <= 1'b1;
      rdc("ctrl_a_rerun", TMR_OFS_CTRL_A, 8'h00);
      chk("pad_a_oe_rst", {31'h0, PAD_A_OE}, 32'h0);
      $display("done: mid-run reset");
      results();
   end
endmodule
`default_nettype wire
